// file: hdl/bsc_regs.svh
// Constants of the boundary-scan chain: lengths, cell positions, codes and timing counts.
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH
`define BSC_CHAIN_LEN   213
`define BSC_CHAIN_LAST  212
`define BSC_IR_W        4
`define BSC_IR_EXTEST   4'h0
`define BSC_IR_SAMPLE   4'h1
`define BSC_IR_PRELOAD  4'h2
`define BSC_IR_IDCODE   4'h3
`define BSC_IR_BYPASS   4'hF
`define BSC_IR_CAPTURE  4'h1
`define BSC_ID_W        32
`define BSC_OE_A0_CELL  89
`define BSC_OE_A8_CELL  72
`define BSC_OE_A16_CELL 55
`define BSC_OE_D0_CELL  34
`define BSC_OE_WR_CELL  12
`define BSC_ACT_LOW_CYC 2'h2
`endif

// file: hdl/bsc_pkg.sv
// Types shared by the boundary-scan modules.
`default_nettype none
`include "bsc_regs.svh"
package bsc_pkg;
	typedef enum logic [3:0] {
		BSC_TLR    = 4'h0, BSC_RTI    = 4'h1, BSC_SEL_DR = 4'h2, BSC_CAP_DR = 4'h3,
		BSC_SH_DR  = 4'h4, BSC_EX1_DR = 4'h5, BSC_PA_DR  = 4'h6, BSC_EX2_DR = 4'h7,
		BSC_UP_DR  = 4'h8, BSC_SEL_IR = 4'h9, BSC_CAP_IR = 4'hA, BSC_SH_IR  = 4'hB,
		BSC_EX1_IR = 4'hC, BSC_PA_IR  = 4'hD, BSC_EX2_IR = 4'hE, BSC_UP_IR  = 4'hF
	} bsc_tap_state_t;
	typedef enum logic [3:0] {
		BSC_EXTEST  = `BSC_IR_EXTEST,
		BSC_SAMPLE  = `BSC_IR_SAMPLE,
		BSC_PRELOAD = `BSC_IR_PRELOAD,
		BSC_IDCODE  = `BSC_IR_IDCODE,
		BSC_BYPASS  = `BSC_IR_BYPASS
	} bsc_instr_t;
endpackage
`default_nettype wire

// file: hdl/bsc_tap_if.sv
// Link between the scan core and its TAP state machine.
`timescale 1ns/1ps
`default_nettype none
interface bsc_tap_if;
	import bsc_pkg::*;
	logic           step;
	logic           tms;
	logic           hold;
	bsc_tap_state_t state;
	modport ctrl (input step, input tms, input hold, output state);
	modport core (output step, output tms, output hold, input state);
endinterface
`default_nettype wire

// file: hdl/bsc_tap_fsm.sv
// TAP controller state machine, advanced once per sampled rising test-clock edge.
`timescale 1ns/1ps
`default_nettype none
module bsc_tap_fsm
	import bsc_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rstn,
	// Scan core side.
	bsc_tap_if.ctrl  tap
);
	bsc_tap_state_t state_q;
	bsc_tap_state_t state_d;

	assign tap.state = state_q;

	always_comb begin
		unique case (state_q)
			BSC_TLR:    state_d = tap.tms ? BSC_TLR    : BSC_RTI;
			BSC_RTI:    state_d = tap.tms ? BSC_SEL_DR : BSC_RTI;
			BSC_SEL_DR: state_d = tap.tms ? BSC_SEL_IR : BSC_CAP_DR;
			BSC_CAP_DR: state_d = tap.tms ? BSC_EX1_DR : BSC_SH_DR;
			BSC_SH_DR:  state_d = tap.tms ? BSC_EX1_DR : BSC_SH_DR;
			BSC_EX1_DR: state_d = tap.tms ? BSC_UP_DR  : BSC_PA_DR;
			BSC_PA_DR:  state_d = tap.tms ? BSC_EX2_DR : BSC_PA_DR;
			BSC_EX2_DR: state_d = tap.tms ? BSC_UP_DR  : BSC_SH_DR;
			BSC_UP_DR:  state_d = tap.tms ? BSC_SEL_DR : BSC_RTI;
			BSC_SEL_IR: state_d = tap.tms ? BSC_TLR    : BSC_CAP_IR;
			BSC_CAP_IR: state_d = tap.tms ? BSC_EX1_IR : BSC_SH_IR;
			BSC_SH_IR:  state_d = tap.tms ? BSC_EX1_IR : BSC_SH_IR;
			BSC_EX1_IR: state_d = tap.tms ? BSC_UP_IR  : BSC_PA_IR;
			BSC_PA_IR:  state_d = tap.tms ? BSC_EX2_IR : BSC_PA_IR;
			BSC_EX2_IR: state_d = tap.tms ? BSC_UP_IR  : BSC_SH_IR;
			BSC_UP_IR:  state_d = tap.tms ? BSC_SEL_DR : BSC_RTI;
		endcase
	end

	// While the port is not activated the machine sits in reset.
	always_ff @(posedge sys_clk) begin
		if (!rstn || tap.hold) begin
			state_q <= BSC_TLR;
		end else if (tap.step) begin
			state_q <= state_d;
		end
	end
endmodule // bsc_tap_fsm
`default_nettype wire

// file: hdl/bsc_scan_top.sv
// Boundary-scan test access port: activation, instruction and data registers, chain.
`timescale 1ns/1ps
`default_nettype none
module bsc_scan_top
	import bsc_pkg::*;
#(
	parameter logic [`BSC_ID_W-1:0] ID_VALUE = 32'h1234_5679 // Arbitrary value.
) (
	// Clock and reset.
	input  wire logic                      sys_clk,
	input  wire logic                      rstn,
	// Device reset pin, sampled for activation.
	input  wire logic                      dev_reset_pin_n,
	// Test link pins.
	input  wire logic                      tck,
	input  wire logic                      tms,
	input  wire logic                      tdi,
	output var  logic                      tdo,
	output var  logic                      tdo_oe,
	// Pad and core side.
	input  wire logic [`BSC_CHAIN_LEN-1:0] cell_obs,
	output var  logic [`BSC_CHAIN_LEN-1:0] cell_upd,
	output var  logic                      extest_mode,
	output var  logic                      tap_active,
	output var  logic [2:0]                addr_oe,
	output var  logic                      data_oe,
	output var  logic                      strobe_oe
);
	function automatic logic is_bsr(input logic [`BSC_IR_W-1:0] code);
		return code == BSC_EXTEST || code == BSC_SAMPLE || code == BSC_PRELOAD;
	endfunction

	bsc_tap_if tap ();

	logic [3:0]                sync1_q;
	logic [3:0]                sync2_q;
	logic                      tck_prev_q;
	logic                      rst_prev_q;
	logic [1:0]                low_cnt_q;
	logic                      active_q;
	logic [`BSC_IR_W-1:0]      ir_sr_q;
	logic [`BSC_IR_W-1:0]      ir_q;
	logic [`BSC_ID_W-1:0]      id_sr_q;
	logic                      byp_q;
	logic [`BSC_CHAIN_LEN-1:0] bsr_q;
	logic [`BSC_CHAIN_LEN-1:0] upd_q;
	logic                      tdo_q;
	logic                      tdo_oe_q;
	logic                      extest_q;

	wire tck_s  = sync2_q[0];
	wire tdi_s  = sync2_q[2];
	wire rst_s  = sync2_q[3];
	wire rise   = tck_s && !tck_prev_q;
	wire fall   = !tck_s && tck_prev_q;
	wire sel_bsr = is_bsr(ir_q);
	wire sel_id  = ir_q == BSC_IDCODE;
	wire sel_byp = !sel_bsr && !sel_id;
	wire st_tlr  = tap.state == BSC_TLR;
	wire st_capd = tap.state == BSC_CAP_DR;
	wire st_shd  = tap.state == BSC_SH_DR;
	wire st_capi = tap.state == BSC_CAP_IR;
	wire st_shi  = tap.state == BSC_SH_IR;
	wire bsr_cap = rise && sel_bsr && st_capd;
	wire bsr_sh  = rise && sel_bsr && st_shd;
	wire upd_en  = fall && sel_bsr && tap.state == BSC_UP_DR;
	wire ir_load = fall && tap.state == BSC_UP_IR;
	wire act_rel = rst_s && !rst_prev_q;
	wire [`BSC_CHAIN_LEN-1:0] bsr_in = {bsr_q[`BSC_CHAIN_LAST-1:0], tdi_s};
	wire dr_out = sel_bsr ? bsr_q[`BSC_CHAIN_LAST] : (sel_id ? id_sr_q[0] : byp_q);

	assign tap.step = rise;
	assign tap.tms  = sync2_q[1];
	assign tap.hold = !active_q;

	bsc_tap_fsm u_fsm (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.tap     (tap)
	);

	// The test clock is far slower than sys_clk, so edges are found by sampling.
	always_ff @(posedge sys_clk) begin
		sync1_q    <= {dev_reset_pin_n, tdi, tms, tck};
		sync2_q    <= sync1_q;
		tck_prev_q <= tck_s;
		rst_prev_q <= rst_s;
	end

	// Counts system clocks with the test clock low while the reset pin is held.
	always_ff @(posedge sys_clk) begin
		if (!rstn || tck_s || rst_s) begin
			low_cnt_q <= 2'h0;
		end else if (low_cnt_q != `BSC_ACT_LOW_CYC) begin
			low_cnt_q <= low_cnt_q + 2'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			active_q <= 1'b0;
		end else if (act_rel) begin
			active_q <= low_cnt_q == `BSC_ACT_LOW_CYC;
		end
	end

	// Instruction shift and update; reset selects the identification register.
	always_ff @(posedge sys_clk) begin
		if (!rstn || st_tlr) begin
			ir_sr_q <= `BSC_IR_CAPTURE;
			ir_q    <= BSC_IDCODE;
		end else begin
			if (rise && st_capi) begin
				ir_sr_q <= `BSC_IR_CAPTURE;
			end else if (rise && st_shi) begin
				ir_sr_q <= {tdi_s, ir_sr_q[`BSC_IR_W-1:1]};
			end
			if (ir_load) begin
				ir_q <= ir_sr_q;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			id_sr_q <= ID_VALUE;
			byp_q   <= 1'b0;
		end else begin
			if (rise && sel_id && st_capd) begin
				id_sr_q <= ID_VALUE;
			end else if (rise && sel_id && st_shd) begin
				id_sr_q <= {tdi_s, id_sr_q[`BSC_ID_W-1:1]};
			end
			if (rise && sel_byp && st_capd) begin
				byp_q <= 1'b0;
			end else if (rise && sel_byp && st_shd) begin
				byp_q <= tdi_s;
			end
		end
	end

	// Every cell observes and drives, so one capture and one update stage per cell.
	for (genvar i = 0; i < `BSC_CHAIN_LEN; i++) begin : g_cell
		always_ff @(posedge sys_clk) begin
			if (!rstn) begin
				bsr_q[i] <= 1'b0;
				upd_q[i] <= 1'b0;
			end else begin
				if (bsr_cap) begin
					bsr_q[i] <= cell_obs[i];
				end else if (bsr_sh) begin
					bsr_q[i] <= bsr_in[i];
				end
				if (upd_en) begin
					upd_q[i] <= bsr_q[i];
				end
			end
		end
	end

	// TDO moves on the falling edge so the tester samples a settled bit on the rise.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			tdo_q    <= 1'b0;
			tdo_oe_q <= 1'b0;
			extest_q <= 1'b0;
		end else begin
			if (fall) begin
				tdo_q    <= st_shi ? ir_sr_q[0] : dr_out;
				tdo_oe_q <= st_shi || st_shd;
			end
			extest_q <= ir_q == BSC_EXTEST;
		end
	end

	assign tdo         = tdo_q;
	assign tdo_oe      = tdo_oe_q;
	assign cell_upd    = upd_q;
	assign extest_mode = extest_q;
	assign tap_active  = active_q;
	assign addr_oe     = {upd_q[`BSC_OE_A16_CELL], upd_q[`BSC_OE_A8_CELL], upd_q[`BSC_OE_A0_CELL]};
	assign data_oe     = upd_q[`BSC_OE_D0_CELL];
	assign strobe_oe   = upd_q[`BSC_OE_WR_CELL];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	property p_act_ok;
		act_rel && low_cnt_q == `BSC_ACT_LOW_CYC |=> tap_active;
	endproperty
	a_act_ok: assert property (p_act_ok) else $error("port not activated");
	property p_act_no;
		act_rel && low_cnt_q != `BSC_ACT_LOW_CYC |=> !tap_active ##1 st_tlr;
	endproperty
	a_act_no: assert property (p_act_no) else $error("port activated too early");
	property p_cap;
		bsr_cap |=> bsr_q == $past(cell_obs);
	endproperty
	a_cap: assert property (p_cap) else $error("capture missed");
	property p_shift;
		bsr_sh |=> bsr_q == {$past(bsr_q[`BSC_CHAIN_LAST-1:0]), $past(tdi_s)};
	endproperty
	a_shift: assert property (p_shift) else $error("shift wrong");
	property p_upd;
		!$stable(cell_upd) |-> $past(upd_en);
	endproperty
	a_upd: assert property (p_upd) else $error("update outside update edge");
	property p_extest;
		ir_load && ir_sr_q == BSC_EXTEST |=> sel_bsr ##1 extest_mode;
	endproperty
	a_extest: assert property (p_extest) else $error("extest not entered");
	property p_only_sel;
		!$stable(bsr_q) |-> $past(sel_bsr);
	endproperty
	a_only_sel: assert property (p_only_sel) else $error("chain moved unselected");
	property p_addr_oe;
		upd_en |=> addr_oe[0] == $past(bsr_q[`BSC_OE_A0_CELL]) &&
			addr_oe[1] == $past(bsr_q[`BSC_OE_A8_CELL]) &&
			addr_oe[2] == $past(bsr_q[`BSC_OE_A16_CELL]);
	endproperty
	a_addr_oe: assert property (p_addr_oe) else $error("address enable wrong");
	property p_data_oe;
		upd_en |=> data_oe == $past(bsr_q[`BSC_OE_D0_CELL]);
	endproperty
	a_data_oe: assert property (p_data_oe) else $error("data enable wrong");
	property p_strb_oe;
		upd_en |=> strobe_oe == $past(bsr_q[`BSC_OE_WR_CELL]);
	endproperty
	a_strb_oe: assert property (p_strb_oe) else $error("strobe enable wrong");
	property p_tdo;
		fall && sel_bsr && st_shd |=> tdo == $past(bsr_q[`BSC_CHAIN_LAST]) && tdo_oe;
	endproperty
	a_tdo: assert property (p_tdo) else $error("tdo not last cell");
	property p_byp;
		rise && sel_byp && st_shd |=> byp_q == $past(tdi_s);
	endproperty
	a_byp: assert property (p_byp) else $error("bypass bit wrong");
	c_upd:    cover property (upd_en && extest_mode);
	c_byp:    cover property (rise && sel_byp && st_shd);
	c_active: cover property ($rose(tap_active));
endmodule // bsc_scan_top
`default_nettype wire

// file: verification/bsc_jtag_ctl.sv
// Behavioural test controller that drives the four-wire test link.
`timescale 1ns/1ps
`default_nettype none
module bsc_jtag_ctl (
	// Clock that paces the link phases.
	input  wire logic sys_clk,
	// Test link pins.
	output var  logic tck,
	output var  logic tms,
	output var  logic tdi,
	input  wire logic tdo
);
	int half = 4;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	task automatic park(input logic v);
		@(posedge sys_clk) tck <= v;
	endtask
	// The data output is read just before the fall, so it never races its own change.
	task automatic step(input logic m, input logic d, output logic o);
		tms <= m;
		tdi <= d;
		repeat (half) @(posedge sys_clk);
		tck <= 1'b1;
		repeat (half) @(posedge sys_clk);
		o = tdo;
		tck <= 1'b0;
	endtask
	task automatic shift(input bit ir, input int n, input bit msb,
		input logic [212:0] din, output logic [212:0] dout);
		logic o;
		int   k;
		dout = '0;
		step(1'b1, 1'b0, o);
		if (ir) begin
			step(1'b1, 1'b0, o);
		end
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			k = msb ? n - 1 - i : i;
			step(i == n - 1, din[k], o);
			dout[k] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule // bsc_jtag_ctl
`default_nettype wire

// file: verification/boundary_scan_chain_control_tb_top.sv
// Self-checking bench for the boundary-scan port.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_regs.svh"
module boundary_scan_chain_control_tb_top;
	import bsc_pkg::*;
	typedef struct packed {logic [3:0] code; logic ext; logic [1:0] kind;} bsc_row_t;
	localparam logic [31:0] TB_ID = 32'h5A5A_1234; // Arbitrary value.
	localparam bsc_row_t ROWS [6] = '{'{`BSC_IR_EXTEST, 1'b1, 2'h0},
		'{`BSC_IR_SAMPLE, 1'b0, 2'h0}, '{`BSC_IR_PRELOAD, 1'b0, 2'h0},
		'{`BSC_IR_IDCODE, 1'b0, 2'h1}, '{`BSC_IR_BYPASS, 1'b0, 2'h2}, '{4'h7, 1'b0, 2'h2}};
	logic         sys_clk, rstn, dev_reset_pin_n, tck, tms, tdi, tdo, tdo_oe, o;
	logic         extest_mode, tap_active, data_oe, strobe_oe;
	logic [2:0]   addr_oe;
	logic [212:0] cell_obs, cell_upd, dout, pat, upd;
	int           n_mismatch, tests_run;
	bsc_scan_top #(.ID_VALUE(TB_ID)) dut (.sys_clk(sys_clk), .rstn(rstn),
		.dev_reset_pin_n(dev_reset_pin_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe), .cell_obs(cell_obs), .cell_upd(cell_upd),
		.extest_mode(extest_mode), .tap_active(tap_active), .addr_oe(addr_oe),
		.data_oe(data_oe), .strobe_oe(strobe_oe));
	bsc_jtag_ctl ctl (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	always #12.5 sys_clk = ~sys_clk;
	task automatic chk(input logic [212:0] got, input logic [212:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic activate(input logic tck_v, input logic exp);
		ctl.park(tck_v);
		dev_reset_pin_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		dev_reset_pin_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk(213'(tap_active), 213'(exp));
		ctl.park(1'b0);
	endtask
	initial begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		dev_reset_pin_n = 1'b1;
		cell_obs = '0;
		n_mismatch = 0;
		tests_run = 0;
		upd = '0;
		pat = {5'h0B, {4{52'hC3A5_96F0_1E2D_4}}};
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		chk(cell_upd, '0);
		activate(1'b1, 1'b0);
		activate(1'b0, 1'b1);
		ctl.step(1'b0, 1'b0, o);
		for (int r = 0; r < 6; r++) begin
			ctl.half = (r % 2) ? 6 : 4;
			pat = {pat[200:0], pat[212:201]} ^ 213'(r);
			cell_obs <= pat;
			ctl.shift(1'b1, `BSC_IR_W, 1'b0, 213'(ROWS[r].code), dout);
			chk(213'(dout[3:0]), 213'(`BSC_IR_CAPTURE));
			chk(213'(extest_mode), 213'(ROWS[r].ext));
			if (ROWS[r].kind == 2'h0) begin
				ctl.shift(1'b0, `BSC_CHAIN_LEN, 1'b1, ~pat, dout);
				upd = ~pat;
				chk(dout, pat);
				chk(cell_upd, upd);
				chk(213'({addr_oe, data_oe, strobe_oe}),
					213'({upd[55], upd[72], upd[89], upd[34], upd[12]}));
			end else if (ROWS[r].kind == 2'h1) begin
				ctl.shift(1'b0, `BSC_ID_W, 1'b0, pat, dout);
				chk(213'(dout[31:0]), 213'(TB_ID));
				chk(cell_upd, upd);
			end else begin
				ctl.shift(1'b0, 9, 1'b0, pat, dout);
				chk(213'(dout[8:0]), 213'({pat[7:0], 1'b0}));
				chk(cell_upd, upd);
			end
		end
		// A reset in mid-shift must leave the port idle and the update stage cleared.
		fork
			ctl.shift(1'b0, `BSC_CHAIN_LEN, 1'b1, pat, dout);
			begin
				repeat (500) @(posedge sys_clk);
				chk(213'(tdo_oe), 213'(1'b1));
				rstn <= 1'b0;
				repeat (12) @(posedge sys_clk);
				rstn <= 1'b1;
			end
		join
		chk(cell_upd, '0);
		chk(213'(tap_active), 213'(1'b0));
		chk(213'(tdo_oe), '0);
		complete_run();
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		n_mismatch++;
		complete_run();
	end
endmodule // boundary_scan_chain_control_tb_top
`default_nettype wire
